// ---- hdl/video_path.sv ----
// character memory, address mapping, memory buffer and video shifter
`timescale 1ns/100ps

module video_path (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // position and working registers from the sequencer
  input wire logic [video_path_pkg::XPOS_W-1:0] i_x_pos,
  input wire logic [video_path_pkg::YPOS_W-1:0] i_y_pos,
  input wire logic [video_path_pkg::CHAR_W-1:0] i_work_accumulator,
  input wire logic [video_path_pkg::CHAR_W-1:0] i_b_reg,
  input wire logic [video_path_pkg::CHAR_W-1:0] i_rx_data,
  // ram write request and memory buffer fetch
  input wire video_path_pkg::ram_write_t i_ram_wr,
  input wire logic i_fetch_strobe,
  input wire logic i_char_load_strobe,
  // microcode store
  input wire logic [video_path_pkg::UC_AW-1:0] i_ucode_addr,
  input wire logic i_ucode_load,
  input wire logic [video_path_pkg::UC_W-1:0] i_ucode_load_data,
  // character generator store
  input wire logic i_cg_load,
  input wire logic [video_path_pkg::CG_AW-1:0] i_cg_load_addr,
  input wire logic [video_path_pkg::CHAR_W-1:0] i_cg_load_data,
  // video amplifier side
  input wire logic i_video_ready,
  // outputs
  output logic [video_path_pkg::CHAR_W-1:0] o_mem_buf,
  output video_path_pkg::ucode_word_t o_ucode_word,
  output video_path_pkg::ucode_instr_t o_ucode_instr,
  output logic o_line_ready,
  output logic o_video_n,
  output logic o_video_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // address mapping
  logic [video_path_pkg::ROW_W-1:0] y_row;
  logic beyond;
  logic [video_path_pkg::ROW_W-1:0] map_row;
  logic [video_path_pkg::COL_W-1:0] map_col;
  logic [video_path_pkg::PROG_AW-1:0] prog_addr;
  logic bank_sel;
  logic [video_path_pkg::BANK_AW-1:0] bank_addr;

  // y lsb picks the bank, upper four y bits are the ram row below X_SPLIT and ROW_SPLIT
  assign y_row = i_y_pos[video_path_pkg::YPOS_W-1:1];
  assign beyond = (i_x_pos >= video_path_pkg::X_SPLIT) ||
                  (y_row >= video_path_pkg::ROW_SPLIT);

  always_comb begin
    if (beyond) begin
      map_row = {video_path_pkg::HIGH_ROWS, y_row[1:0]};
      map_col = {y_row[3:2], i_x_pos[video_path_pkg::XLOW_MSB:0]};
    end else begin
      map_row = y_row;
      map_col = i_x_pos[video_path_pkg::COL_W-1:0];
    end
  end

  assign prog_addr = {map_row, map_col, i_y_pos[0]};
  assign bank_sel = prog_addr[0];
  assign bank_addr = prog_addr[video_path_pkg::PROG_AW-1:1];

  ////////////////////////////////////////////////////////////////////////////
  // microcode store and decode
  logic [video_path_pkg::UC_W-1:0] ucode_mem [video_path_pkg::UC_WORDS];
  video_path_pkg::ucode_word_t ucode_q;
  video_path_pkg::ucode_instr_t instr_d;

  always_ff @(posedge i_ref_clk) begin
    if (i_ucode_load) begin
      ucode_mem[i_ucode_addr] <= i_ucode_load_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ucode_q <= '0;
    end else begin
      ucode_q <= video_path_pkg::ucode_word_t'(ucode_mem[i_ucode_addr]);
    end
  end

  always_comb begin
    instr_d.load_ram_from_rom = ucode_q.a;
    instr_d.group = {ucode_q.b, ucode_q.c, ucode_q.d};
    instr_d.actions = ucode_q.a ? 4'h0 :
                      {ucode_q.e, ucode_q.f, ucode_q.g, ucode_q.h};
    instr_d.no_action = !ucode_q.a &&
                        ({ucode_q.e, ucode_q.f, ucode_q.g, ucode_q.h} == 4'h0);
  end

  assign o_ucode_word = ucode_q;
  assign o_ucode_instr = instr_d;

  ////////////////////////////////////////////////////////////////////////////
  // character ram: two banks, write source multiplexer
  logic [video_path_pkg::CHAR_W-1:0] bank_even [video_path_pkg::BANK_WORDS];
  logic [video_path_pkg::CHAR_W-1:0] bank_odd [video_path_pkg::BANK_WORDS];
  video_path_pkg::write_src_t wr_src;
  logic [video_path_pkg::CHAR_W-1:0] wr_data;
  logic [video_path_pkg::CHAR_W-1:0] rd_data;

  assign wr_src = video_path_pkg::write_src_t'({i_ram_wr.src_hi,
                                                i_ram_wr.src_lo});

  always_comb begin
    case (wr_src)
      video_path_pkg::SRC_ACCUM: begin
        wr_data = i_work_accumulator;
      end
      video_path_pkg::SRC_BREG: begin
        wr_data = i_b_reg;
      end
      video_path_pkg::SRC_UCODE: begin
        // low seven bits of the microcode word
        wr_data = ucode_q[video_path_pkg::CHAR_W-1:0];
      end
      video_path_pkg::SRC_RXDATA: begin
        wr_data = i_rx_data;
      end
      default: begin
        wr_data = i_work_accumulator;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_ram_wr.en && !bank_sel) begin
      bank_even[bank_addr] <= wr_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_ram_wr.en && bank_sel) begin
      bank_odd[bank_addr] <= wr_data;
    end
  end

  assign rd_data = bank_sel ? bank_odd[bank_addr] : bank_even[bank_addr];

  ////////////////////////////////////////////////////////////////////////////
  // memory buffer
  logic [video_path_pkg::CHAR_W-1:0] mem_buf_q;
  logic char_load_ok;
  logic buf_load;

  // a character load is taken only while the line buffer has room
  assign char_load_ok = i_char_load_strobe && o_line_ready;
  assign buf_load = i_fetch_strobe || char_load_ok;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      mem_buf_q <= video_path_pkg::CHAR_RST;
    end else if (buf_load) begin
      mem_buf_q <= rd_data;
    end
  end

  assign o_mem_buf = mem_buf_q;

  ////////////////////////////////////////////////////////////////////////////
  // character generator
  logic [video_path_pkg::CHAR_W-1:0] cg_mem [video_path_pkg::CG_WORDS];
  logic [video_path_pkg::CG_AW-1:0] cg_addr;
  logic [video_path_pkg::CHAR_W-1:0] glyph_line_bits;

  always_ff @(posedge i_ref_clk) begin
    if (i_cg_load) begin
      cg_mem[i_cg_load_addr] <= i_cg_load_data;
    end
  end

  assign cg_addr = {mem_buf_q, i_work_accumulator[video_path_pkg::LINE_W-1:0]};
  assign glyph_line_bits = cg_mem[cg_addr];

  ////////////////////////////////////////////////////////////////////////////
  // two-entry glyph line buffer
  logic [video_path_pkg::CHAR_W-1:0] fifo_mem [video_path_pkg::FIFO_DEPTH];
  logic fifo_wr_q;
  logic fifo_rd_q;
  logic [1:0] fifo_cnt_q;
  logic fifo_push;
  logic fifo_pop;
  logic fifo_valid;

  assign o_line_ready = (fifo_cnt_q != 2'h2);
  assign fifo_valid = (fifo_cnt_q != 2'h0);
  assign fifo_push = char_load_ok;

  always_ff @(posedge i_ref_clk) begin
    if (fifo_push) begin
      fifo_mem[fifo_wr_q] <= glyph_line_bits;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      fifo_wr_q <= 1'b0;
      fifo_rd_q <= 1'b0;
    end else begin
      if (fifo_push) begin
        fifo_wr_q <= !fifo_wr_q;
      end
      if (fifo_pop) begin
        fifo_rd_q <= !fifo_rd_q;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      fifo_cnt_q <= 2'h0;
    end else begin
      case ({fifo_push, fifo_pop})
        2'b10: begin
          fifo_cnt_q <= fifo_cnt_q + 2'h1;
        end
        2'b01: begin
          fifo_cnt_q <= fifo_cnt_q - 2'h1;
        end
        default: begin
          fifo_cnt_q <= fifo_cnt_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // video line shifter
  logic [video_path_pkg::CHAR_W-1:0] video_line_shifter_q;
  logic [video_path_pkg::CNT_W-1:0] dots_left_q;
  logic shift_step;

  assign fifo_pop = fifo_valid && (dots_left_q == '0);
  assign shift_step = (dots_left_q != '0) && i_video_ready;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      video_line_shifter_q <= video_path_pkg::BLANK_LINE;
      dots_left_q <= '0;
    end else if (fifo_pop) begin
      video_line_shifter_q <= fifo_mem[fifo_rd_q];
      dots_left_q <= video_path_pkg::DOTS_PER_CHAR;
    end else if (shift_step) begin
      // msb first, ones refill so an idle line stays dark
      video_line_shifter_q <= {video_line_shifter_q[5:0], 1'b1};
      dots_left_q <= dots_left_q - 3'h1;
    end
  end

  assign o_video_n = video_line_shifter_q[video_path_pkg::CHAR_W-1];
  assign o_video_valid = (dots_left_q != '0);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_load_accepted;
    fifo_pop;
  endsequence

  sequence s_first_dot;
    o_video_valid && (dots_left_q == video_path_pkg::DOTS_PER_CHAR);
  endsequence

  AST_MAP_SCRATCH: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (y_row >= video_path_pkg::ROW_SPLIT) |->
      (bank_addr[9:8] == 2'h3 && bank_addr[5:4] == 2'h3 &&
       bank_addr[3:0] == i_x_pos[3:0]))
    else $error("scratch row not mapped to top section");

  AST_MAP_MAIN: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_x_pos < 7'h40 && y_row < 4'hc) |->
      (bank_addr == {y_row, i_x_pos[5:0]}))
    else $error("main screen area mapped wrongly");

  AST_MAP_SIDE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_x_pos >= 7'h40) |->
      (map_row[3:2] == 2'b11 && map_col[5:4] == y_row[3:2]))
    else $error("side columns mapped wrongly");

  AST_BANK_LSB: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    bank_sel == i_y_pos[0])
    else $error("bank select not taken from address lsb");

  AST_BUF_FETCH: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_fetch_strobe && !i_ram_wr.en) |=>
      (o_mem_buf == $past(rd_data)))
    else $error("memory buffer missed a fetch");

  AST_BUF_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !buf_load |=> $stable(o_mem_buf))
    else $error("memory buffer changed without a strobe");

  AST_LOAD_PAIR: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    char_load_ok |=> (o_mem_buf == $past(rd_data)) &&
                     (fifo_cnt_q != 2'h0))
    else $error("character load did not update buffer and line");

  AST_SEVEN_DOTS: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_load_accepted |=> s_first_dot)
    else $error("shifter not loaded with seven dots");

  AST_MSB_FIRST: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_load_accepted |=>
      (o_video_n == $past(fifo_mem[fifo_rd_q][6])))
    else $error("first dot is not bit six");

  AST_SHIFT_STEP: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (shift_step && !fifo_pop) |=>
      (o_video_n == $past(video_line_shifter_q[5])))
    else $error("shifter did not advance one dot");

  AST_IDLE_DARK: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !o_video_valid |-> o_video_n)
    else $error("screen lit while no dot is valid");

  AST_WR_SRC: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_ram_wr.en && wr_src == video_path_pkg::SRC_BREG) |->
      (wr_data == i_b_reg))
    else $error("write source select wrong");

endmodule // video_path

// ---- hdl/video_path_pkg.sv ----
// constants and types for the character memory and video path
package video_path_pkg;
  // character word and position widths
  localparam int CHAR_W = 7;
  localparam int XPOS_W = 7;
  localparam int YPOS_W = 5;
  localparam int ROW_W = 4;
  localparam int COL_W = 6;
  localparam int BANK_AW = 10;
  localparam int PROG_AW = 11;
  localparam int BANK_WORDS = 1024;
  localparam int LINE_W = 3;
  localparam int CNT_W = 3;
  // position mapping thresholds and fields
  localparam logic [XPOS_W-1:0] X_SPLIT = 7'h40;
  localparam logic [ROW_W-1:0] ROW_SPLIT = 4'hc;
  localparam logic [1:0] HIGH_ROWS = 2'h3;
  localparam int XLOW_MSB = 3;
  // character generator and microcode stores
  localparam int CG_AW = 10;
  localparam int CG_WORDS = 1024;
  localparam int UC_AW = 10;
  localparam int UC_WORDS = 1024;
  localparam int UC_W = 8;
  // video shifter, line buffer depth and memory buffer reset value
  localparam logic [CNT_W-1:0] DOTS_PER_CHAR = 3'h7;
  localparam logic [CHAR_W-1:0] BLANK_LINE = 7'h7f;
  localparam logic [CHAR_W-1:0] CHAR_RST = 7'h00;
  localparam int FIFO_DEPTH = 2;

  // write data sources
  typedef enum logic [1:0] {
    SRC_ACCUM = 2'b00,
    SRC_BREG = 2'b01,
    SRC_UCODE = 2'b10,
    SRC_RXDATA = 2'b11
  } write_src_t;

  // microcode word, bits named a (msb) through h (lsb)
  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
    logic e;
    logic f;
    logic g;
    logic h;
  } ucode_word_t;

  // decoded instruction
  typedef struct packed {
    logic load_ram_from_rom;
    logic [2:0] group;
    logic [3:0] actions;
    logic no_action;
  } ucode_instr_t;

  // write request toward the character memory
  typedef struct packed {
    logic en;
    logic src_lo;
    logic src_hi;
  } ram_write_t;
endpackage

// ---- tb/video_amp_model.sv ----
// video amplifier model taking the serial dot stream
`timescale 1ns/100ps
module video_amp_model (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // dot stream from the block
  input wire logic i_video_n,
  input wire logic i_video_valid,
  // behaviour: 0 stalls, 1 takes every dot, 2 is ready on every other cycle
  input wire logic [1:0] i_mode,
  // handshake and captured dots
  output logic o_ready,
  output logic [7:0] o_dot_count,
  output logic [31:0] o_dot_bits
);
  logic ready_q = 1'b0;

  assign o_ready = ready_q;

  ////////////////////////////////////////////////////////////////////////////
  // ready changes only just after the falling edge
  always @(negedge i_ref_clk) begin
    ready_q <= (i_mode == 2'h1) || ((i_mode == 2'h2) && !ready_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  // a dot is taken at each rising edge with valid and ready
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_dot_count <= 8'h00;
      o_dot_bits <= 32'h0000_0000;
    end else if (i_video_valid && ready_q) begin
      o_dot_count <= o_dot_count + 8'h01;
      o_dot_bits <= {o_dot_bits[30:0], i_video_n};
    end
  end
endmodule // video_amp_model

// ---- tb/video_path_tb_top.sv ----
// self-checking testbench for the character memory and video path
`timescale 1ns/100ps
module video_path_tb_top;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [6:0] x = 7'h00;
  logic [4:0] y = 5'h00;
  logic [6:0] acc = 7'h00;
  logic [6:0] b = 7'h00;
  logic [6:0] rx = 7'h00;
  video_path_pkg::ram_write_t wr = '0;
  logic fetch = 1'b0;
  logic cls = 1'b0;
  logic [9:0] ua = 10'h000;
  logic ul = 1'b0;
  logic [7:0] uld = 8'h00;
  logic cgl = 1'b0;
  logic [9:0] cga = 10'h000;
  logic [6:0] cgd = 7'h00;
  logic [1:0] mode = 2'h0;
  logic ready;
  logic [6:0] mem_buf;
  video_path_pkg::ucode_word_t uword;
  video_path_pkg::ucode_instr_t uinstr;
  logic line_ready;
  logic video_n;
  logic video_valid;
  logic [7:0] dot_count;
  logic [31:0] dot_bits;
  int num_errors = 0;
  int samples_checked = 0;
  logic [6:0] px [8] = '{7'h05, 7'h05, 7'h46, 7'h46, 7'h46, 7'h06, 7'h3f,
                         7'h06};
  logic [4:0] py [8] = '{5'h00, 5'h01, 5'h00, 5'h08, 5'h10, 5'h18, 5'h16,
                         5'h00};
  logic [6:0] gl [3] = '{7'h35, 7'h4e, 7'h19};

  always #2.5 i_ref_clk = ~i_ref_clk;

  video_path video_path_i (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_x_pos(x), .i_y_pos(y),
    .i_work_accumulator(acc), .i_b_reg(b), .i_rx_data(rx), .i_ram_wr(wr),
    .i_fetch_strobe(fetch), .i_char_load_strobe(cls), .i_ucode_addr(ua),
    .i_ucode_load(ul), .i_ucode_load_data(uld), .i_cg_load(cgl),
    .i_cg_load_addr(cga), .i_cg_load_data(cgd), .i_video_ready(ready),
    .o_mem_buf(mem_buf), .o_ucode_word(uword), .o_ucode_instr(uinstr),
    .o_line_ready(line_ready), .o_video_n(video_n),
    .o_video_valid(video_valid));

  video_amp_model video_amp_model_i (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_video_n(video_n),
    .i_video_valid(video_valid), .i_mode(mode), .o_ready(ready),
    .o_dot_count(dot_count), .o_dot_bits(dot_bits));

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n = 1);
    repeat (n) @(negedge i_ref_clk);
  endtask

  task automatic ram_wr(input logic [6:0] xv, input logic [4:0] yv,
                        input logic [1:0] s);
    x = xv;
    y = yv;
    wr = '{1'b1, s[0], s[1]};
    step();
    wr = '0;
    step();
  endtask

  task automatic fetch_chk(input logic [6:0] xv, input logic [4:0] yv,
                           input logic [6:0] exp);
    x = xv;
    y = yv;
    fetch = 1'b1;
    step();
    fetch = 1'b0;
    step();
    check(mem_buf, exp);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_reset;
    check(mem_buf, 7'h00);
    check(video_n, 1'b1);
    check(video_valid, 1'b0);
    check(line_ready, 1'b1);
    $display("test reset done");
  endtask

  task automatic test_mapping;
    for (int i = 0; i < 8; i++) begin
      acc = 7'h60 ^ i[6:0];
      ram_wr(px[i], py[i], 2'b00);
    end
    for (int i = 0; i < 8; i++) begin
      fetch_chk(px[i], py[i], 7'h60 ^ i[6:0]);
    end
    fetch_chk(7'h16, 5'h18, 7'h65);
    fetch_chk(7'h46, 5'h18, 7'h65);
    fetch_chk(7'h05, 5'h01, 7'h61);
    $display("test mapping done");
  endtask

  task automatic test_sources;
    logic [6:0] exp [4];
    exp = '{7'h15, 7'h2a, 7'h49, 7'h33};
    acc = 7'h15;
    b = 7'h2a;
    rx = 7'h33;
    ua = 10'h005;
    uld = 8'hc9;
    ul = 1'b1;
    step();
    ul = 1'b0;
    step();
    for (int s = 0; s < 4; s++) begin
      ram_wr(s[6:0], 5'h02, s[1:0]);
    end
    for (int s = 0; s < 4; s++) begin
      fetch_chk(s[6:0], 5'h02, exp[s]);
    end
    $display("test sources done");
  endtask

  task automatic test_ucode;
    ua = 10'h0a0;
    uld = 8'h9a;
    ul = 1'b1;
    step();
    ua = 10'h0a1;
    uld = 8'h3c;
    step();
    ua = 10'h0a2;
    uld = 8'h20;
    step();
    ul = 1'b0;
    ua = 10'h0a0;
    step();
    check(uword, 8'h9a);
    check(uinstr, 9'h120);
    ua = 10'h0a1;
    step();
    check(uword, 8'h3c);
    check(uinstr, 9'h078);
    ua = 10'h0a2;
    step();
    check(uinstr, 9'h041);
    $display("test ucode done");
  endtask

  task automatic test_video;
    int n;
    for (int i = 0; i < 4; i++) begin
      acc = 7'h41 + i[6:0];
      ram_wr(i[6:0], 5'h00, 2'b00);
    end
    cgl = 1'b1;
    for (int i = 0; i < 3; i++) begin
      cga = {7'h41 + i[6:0], 3'h3};
      cgd = gl[i];
      step();
      cga = {7'h41 + i[6:0], 3'h2};
      cgd = ~gl[i];
      step();
    end
    cgl = 1'b0;
    acc = 7'h03;
    mode = 2'h0;
    fetch_chk(7'h00, 5'h00, 7'h41);
    // back-to-back loads with the amplifier stalled
    cls = 1'b1;
    for (int i = 1; i < 4; i++) begin
      x = i[6:0];
      check(line_ready, 1'b1);
      step();
      check(mem_buf, 7'h41 + i[6:0]);
    end
    cls = 1'b0;
    step();
    check(line_ready, 1'b0);
    x = 7'h04;
    cls = 1'b1;
    step();
    cls = 1'b0;
    check(mem_buf, 7'h44);
    check(dot_count, 8'h00);
    mode = 2'h2;
    n = 0;
    while (dot_count != 8'd21 && n < 300) begin
      step();
      n++;
    end
    step(4);
    check(dot_count, 8'd21);
    check(dot_bits[20:0], {gl[0], gl[1], gl[2]});
    check(video_n, 1'b1);
    check(video_valid, 1'b0);
    $display("test video done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    step(5);
    i_rst_n = 1'b1;
    step();
    test_reset();
    test_mapping();
    test_sources();
    test_ucode();
    test_video();
    report_and_stop();
  end

  initial begin
    repeat (5000) @(posedge i_ref_clk);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule // video_path_tb_top
